//--- obt_pkg.sv
`default_nettype none
package obt_pkg;
  // Port and capture widths.
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 5;
  localparam int AXI_W     = 32;
  localparam int LOG_DEPTH = 16;
  localparam int LOG_W     = 2 * DATA_W + 2;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] ADDR_CTRL   = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_L2R    = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_R2L    = 5'h0C;
  localparam logic [ADDR_W-1:0] ADDR_LOG    = 5'h10;

  // Control register layout and reset value (outputs isolated).
  localparam int         CTRL_W         = 4;
  localparam int         CTRL_DRIVE_N   = 0;
  localparam int         CTRL_DIR       = 1;
  localparam int         CTRL_L2R_SEL   = 2;
  localparam int         CTRL_R2L_SEL   = 3;
  localparam logic [3:0] CTRL_RESET     = 4'h1;

  // Status register layout.
  localparam int ST_LOG_AVAIL = 0;
  localparam int ST_LOG_FULL  = 1;
  localparam int ST_LEFT_DRV  = 2;
  localparam int ST_RIGHT_DRV = 3;
  localparam int ST_L2R_VALID = 4;
  localparam int ST_R2L_VALID = 5;
  localparam int ST_OVERFLOW  = 6;
  localparam int ST_W         = 7;

  // Capture log word: bit positions of the two edge flags.
  localparam int LOG_L2R_FLAG = 2 * DATA_W;
  localparam int LOG_R2L_FLAG = 2 * DATA_W + 1;
  localparam int LOG_PAD_W    = AXI_W - LOG_W - 1;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

//--- obt_fifo_if.sv
`timescale 1ns/100ps
`default_nettype none
interface obt_fifo_if #(parameter int WIDTH = 18);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;

  // The block fills and drains; the buffer answers both sides.
  modport user (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready);
  modport buffer (input in_valid, input in_data, output in_ready,
                  output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

//--- obt_fifo.sv
`timescale 1ns/100ps
`default_nettype none
module obt_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic   aclk,
  input wire logic   aresetn,
  // Fill and drain sides.
  obt_fifo_if.buffer port_b
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
  localparam logic [CW-1:0] ONE        = CW'(1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CW-1:0]    count_r;
  logic [WIDTH-1:0] rd_data_r;
  wire              push;
  wire              pop;

  // Full and empty come straight from the occupancy count.
  assign port_b.in_ready  = (count_r != FULL_COUNT);
  assign port_b.out_valid = (count_r != '0);
  assign port_b.out_data  = rd_data_r;
  assign push = port_b.in_valid && port_b.in_ready;
  assign pop  = port_b.out_valid && port_b.out_ready;

  // Storage has no reset; a popped word is in the read register one cycle later.
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr_r] <= port_b.in_data;
    end
    if (pop) begin
      rd_data_r <= mem[rd_ptr_r];
    end
  end

  // Pointers and count.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      wr_ptr_r <= push ? PW'(wr_ptr_r + 1'b1) : wr_ptr_r;
      rd_ptr_r <= pop ? PW'(rd_ptr_r + 1'b1) : rd_ptr_r;
      count_r  <= count_r + (push ? ONE : '0) - (pop ? ONE : '0);
    end
  end
endmodule
`default_nettype wire

//--- obt_transceiver.sv
// How it works
// R1 - Capture clock edges load each direction register.
// R2 - Capture ignores drive enable and direction.
// R3 - Enable high drives nothing; no edge holds.
// R4 - Both edges while isolated store independently.
// R5 - Live right data drives left port.
// R6 - Stored right-to-left register drives left port.
// R7 - Live left data drives right port.
// R8 - Stored left-to-right register drives right port.
// R9 - Capture edges never change driven port.
// R10 - Never drive both ports together.
// R11 - Undriven port data remains capturable.
// R12 - Selects choose live or stored per direction.
// R13 - Outside logic holds unused controls defined.
// R14 - Direction registers unreset, undefined until captured.
//
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module obt_transceiver (
  // Clock and reset.
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write channels.
  input  wire logic [obt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [obt_pkg::AXI_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [obt_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [obt_pkg::AXI_W-1:0]       s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  // Capture clock pins.
  input  wire logic                       left_to_right_capture_clock,
  input  wire logic                       right_to_left_capture_clock,
  // Left port pins.
  input  wire logic [obt_pkg::DATA_W-1:0] left_port_lines_in,
  output logic [obt_pkg::DATA_W-1:0]      left_port_lines_out,
  output logic [obt_pkg::DATA_W-1:0]      left_port_lines_oe_n,
  // Right port pins.
  input  wire logic [obt_pkg::DATA_W-1:0] right_port_lines_in,
  output logic [obt_pkg::DATA_W-1:0]      right_port_lines_out,
  output logic [obt_pkg::DATA_W-1:0]      right_port_lines_oe_n,
  // Capture log back-pressure.
  output logic                            capture_log_ready
);
  localparam int DW = obt_pkg::DATA_W;

  // Address decoding shared by the write and read paths.
  function automatic logic is_mapped(input logic [obt_pkg::ADDR_W-1:0] a);
    is_mapped = (a == obt_pkg::ADDR_CTRL) || (a == obt_pkg::ADDR_STATUS) ||
                (a == obt_pkg::ADDR_L2R) || (a == obt_pkg::ADDR_R2L) ||
                (a == obt_pkg::ADDR_LOG);
  endfunction

  // Port drive decoding shared by the drive logic and the status word.
  function automatic logic drives_left(input logic [obt_pkg::CTRL_W-1:0] c);
    drives_left = !c[obt_pkg::CTRL_DRIVE_N] && !c[obt_pkg::CTRL_DIR];
  endfunction
  function automatic logic drives_right(input logic [obt_pkg::CTRL_W-1:0] c);
    drives_right = !c[obt_pkg::CTRL_DRIVE_N] && c[obt_pkg::CTRL_DIR];
  endfunction

  obt_fifo_if #(.WIDTH(obt_pkg::LOG_W)) log_if ();

  logic [obt_pkg::CTRL_W-1:0] ctrl_r;
  logic [2:0]                 l2r_clk_sh_r;
  logic [2:0]                 r2l_clk_sh_r;
  logic [DW-1:0]              left_s1_r;
  logic [DW-1:0]              left_s2_r;
  logic [DW-1:0]              right_s1_r;
  logic [DW-1:0]              right_s2_r;
  logic [DW-1:0]              l2r_reg_r;
  logic [DW-1:0]              r2l_reg_r;
  logic                       l2r_loaded_r;
  logic                       r2l_loaded_r;
  logic                       overflow_r;
  logic                       aw_held_r;
  logic                       w_held_r;
  logic [obt_pkg::ADDR_W-1:0] awaddr_r;
  logic [obt_pkg::AXI_W-1:0]  wdata_r;
  logic [3:0]                 wstrb_r;
  logic                       rd_pend_r;
  logic                       log_hit_r;
  logic [obt_pkg::ADDR_W-1:0] araddr_r;

  // Pin synchronisers: stage one feeds only stage two.
  always_ff @(posedge aclk) begin
    l2r_clk_sh_r <= {l2r_clk_sh_r[1:0], left_to_right_capture_clock};
    r2l_clk_sh_r <= {r2l_clk_sh_r[1:0], right_to_left_capture_clock};
    left_s1_r    <= left_port_lines_in;
    left_s2_r    <= left_s1_r;
    right_s1_r   <= right_port_lines_in;
    right_s2_r   <= right_s1_r;
  end

  // Rising edges seen after synchronisation; data is aligned with stage two.
  wire l2r_edge = l2r_clk_sh_r[1] && !l2r_clk_sh_r[2];
  wire r2l_edge = r2l_clk_sh_r[1] && !r2l_clk_sh_r[2];

  // R1 R2 capture on edge.
  // No control input gates these loads, and the registers carry no reset.
  always_ff @(posedge aclk) begin
    if (l2r_edge) begin
      l2r_reg_r <= left_s2_r;
    end
    if (r2l_edge) begin
      r2l_reg_r <= right_s2_r;
    end
  end

  // R14 loaded flags.
  // Software learns here whether stored data has any meaning yet.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      l2r_loaded_r <= 1'b0;
      r2l_loaded_r <= 1'b0;
    end else begin
      l2r_loaded_r <= l2r_loaded_r || l2r_edge;
      r2l_loaded_r <= r2l_loaded_r || r2l_edge;
    end
  end

  // R5 R6 R12 left source selection.
  wire [DW-1:0] left_src  = ctrl_r[obt_pkg::CTRL_R2L_SEL] ? r2l_reg_r : right_s2_r;
  // R7 R8 R12 right source selection.
  wire [DW-1:0] right_src = ctrl_r[obt_pkg::CTRL_L2R_SEL] ? l2r_reg_r : left_s2_r;
  wire          left_drv  = drives_left(ctrl_r);
  wire          right_drv = drives_right(ctrl_r);

  // R3 R9 R10 registered port drive.
  // Enables depend only on the control register, so capture edges cannot
  // disturb them and the two decodes are exclusive by construction.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      left_port_lines_out   <= '0;
      right_port_lines_out  <= '0;
      left_port_lines_oe_n  <= '1;
      right_port_lines_oe_n <= '1;
    end else begin
      left_port_lines_out   <= left_src;
      right_port_lines_out  <= right_src;
      left_port_lines_oe_n  <= {DW{!left_drv}};
      right_port_lines_oe_n <= {DW{!right_drv}};
    end
  end

  // R4 R11 capture log feed.
  // One word holds both directions, so simultaneous edges are never split.
  assign log_if.in_valid = l2r_edge || r2l_edge;
  assign log_if.in_data  = {r2l_edge, l2r_edge, right_s2_r, left_s2_r};

  obt_fifo #(
    .WIDTH (obt_pkg::LOG_W),
    .DEPTH (obt_pkg::LOG_DEPTH)
  ) u_log (
    .aclk    (aclk),
    .aresetn (aresetn),
    .port_b  (log_if.buffer)
  );

  // Write channel handshake and register update decode.
  wire aw_take  = s_axi_awvalid && s_axi_awready;
  wire w_take   = s_axi_wvalid && s_axi_wready;
  wire do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  wire wr_hit   = is_mapped(awaddr_r);
  wire wr_ctrl  = do_write && wstrb_r[0] && (awaddr_r == obt_pkg::ADDR_CTRL);
  wire wr_stat  = do_write && wstrb_r[0] && (awaddr_r == obt_pkg::ADDR_STATUS);
  wire ovf_clr  = wr_stat && wdata_r[obt_pkg::ST_OVERFLOW];
  wire ovf_set  = log_if.in_valid && !log_if.in_ready;
  wire aw_held_nxt = aw_held_r ? !do_write : aw_take;
  wire w_held_nxt  = w_held_r ? !do_write : w_take;
  wire bvalid_nxt  = do_write || (s_axi_bvalid && !s_axi_bready);

  // Write address and data may arrive in either order; each is held until
  // the pair is complete, and neither is taken again until the response has been accepted.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= obt_pkg::RESP_OKAY;
    end else begin
      aw_held_r     <= aw_held_nxt;
      w_held_r      <= w_held_nxt;
      s_axi_awready <= !aw_held_nxt && !bvalid_nxt;
      s_axi_wready  <= !w_held_nxt && !bvalid_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      if (do_write) begin
        s_axi_bresp <= wr_hit ? obt_pkg::RESP_OKAY : obt_pkg::RESP_SLVERR;
      end
    end
  end

  // Write payload capture.
  always_ff @(posedge aclk) begin
    if (aw_take) begin
      awaddr_r <= s_axi_awaddr;
    end
    if (w_take) begin
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end
  end

  // Control register and overflow flag; a new overflow beats its clear.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r     <= obt_pkg::CTRL_RESET;
      overflow_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= wdata_r[obt_pkg::CTRL_W-1:0];
      end
      overflow_r <= ovf_set || (overflow_r && !ovf_clr);
    end
  end

  // Read channel: a log read pops in the address cycle, data is muxed later.
  wire ar_take    = s_axi_arvalid && s_axi_arready;
  wire log_pop    = ar_take && (s_axi_araddr == obt_pkg::ADDR_LOG) && log_if.out_valid;
  wire rvalid_nxt = rd_pend_r || (s_axi_rvalid && !s_axi_rready);
  assign log_if.out_ready = log_pop;

  wire [obt_pkg::ST_W-1:0] status_word = {overflow_r, r2l_loaded_r, l2r_loaded_r, right_drv,
                                          left_drv, !log_if.in_ready, log_if.out_valid};
  // An empty log read returns zero rather than a stale word.
  wire [obt_pkg::LOG_W-1:0] log_word = log_hit_r ? log_if.out_data : '0;
  wire [obt_pkg::AXI_W-1:0] rd_mux =
    (araddr_r == obt_pkg::ADDR_CTRL)   ? {{(obt_pkg::AXI_W-obt_pkg::CTRL_W){1'b0}}, ctrl_r} :
    (araddr_r == obt_pkg::ADDR_STATUS) ? {{(obt_pkg::AXI_W-obt_pkg::ST_W){1'b0}}, status_word} :
    (araddr_r == obt_pkg::ADDR_L2R)    ? {{(obt_pkg::AXI_W-DW){1'b0}}, l2r_reg_r} :
    (araddr_r == obt_pkg::ADDR_R2L)    ? {{(obt_pkg::AXI_W-DW){1'b0}}, r2l_reg_r} :
    (araddr_r == obt_pkg::ADDR_LOG)    ? {log_hit_r, {obt_pkg::LOG_PAD_W{1'b0}}, log_word} :
    '0;

  // Read handshake and registered answer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_pend_r     <= 1'b0;
      log_hit_r     <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= obt_pkg::RESP_OKAY;
    end else begin
      rd_pend_r     <= ar_take;
      log_hit_r     <= ar_take ? log_pop : log_hit_r;
      s_axi_arready <= !ar_take && !rd_pend_r && !rvalid_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      if (rd_pend_r) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= is_mapped(araddr_r) ? obt_pkg::RESP_OKAY : obt_pkg::RESP_SLVERR;
      end
    end
  end

  // Read address capture.
  always_ff @(posedge aclk) begin
    if (ar_take) begin
      araddr_r <= s_axi_araddr;
    end
  end

  // Log back-pressure is exported so the source can pace its capture clocks.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_log_ready <= 1'b0;
    end else begin
      capture_log_ready <= log_if.in_ready;
    end
  end

  // Checks of the captures, the loaded flags and the port behaviour against the control register.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_no_dual_drive: assert property ( // R10
    !((left_port_lines_oe_n != '1) && (right_port_lines_oe_n != '1)))
    else $error("Both ports driven at once.");
  a_isolate_ports: assert property ( // R3
    ctrl_r[obt_pkg::CTRL_DRIVE_N] |=> (left_port_lines_oe_n == '1) &&
                                      (right_port_lines_oe_n == '1))
    else $error("A port is driven while drive enable is high.");
  a_left_capture: assert property ( // R1
    l2r_edge |=> l2r_reg_r == $past(left_s2_r))
    else $error("Left data not captured on its edge.");
  a_right_capture: assert property ( // R2
    r2l_edge |=> r2l_reg_r == $past(right_s2_r))
    else $error("Right data not captured on its edge.");
  // Unreset storage is unknown before its first load, so holding is checked after it.
  a_hold_storage: assert property ( // R3
    !l2r_edge && !r2l_edge && l2r_loaded_r && r2l_loaded_r |=>
      $stable(l2r_reg_r) && $stable(r2l_reg_r))
    else $error("A register changed without a capture edge.");
  a_both_isolated: assert property ( // R4
    l2r_edge && r2l_edge && ctrl_r[obt_pkg::CTRL_DRIVE_N] |=>
      (l2r_reg_r == $past(left_s2_r)) && (r2l_reg_r == $past(right_s2_r)))
    else $error("Simultaneous isolated captures not both stored.");
  a_live_left: assert property ( // R5
    left_drv && !ctrl_r[obt_pkg::CTRL_R2L_SEL] |=>
      (left_port_lines_oe_n == '0) && (left_port_lines_out == $past(right_s2_r)))
    else $error("Left port does not carry live right data.");
  a_stored_left: assert property ( // R6
    left_drv && ctrl_r[obt_pkg::CTRL_R2L_SEL] |=>
      (left_port_lines_oe_n == '0) && (left_port_lines_out == $past(r2l_reg_r)))
    else $error("Left port does not carry stored data.");
  a_live_right: assert property ( // R7
    right_drv && !ctrl_r[obt_pkg::CTRL_L2R_SEL] |=>
      (right_port_lines_oe_n == '0) && (right_port_lines_out == $past(left_s2_r)))
    else $error("Right port does not carry live left data.");
  a_stored_right: assert property ( // R8
    right_drv && ctrl_r[obt_pkg::CTRL_L2R_SEL] |=>
      (right_port_lines_oe_n == '0) && (right_port_lines_out == $past(l2r_reg_r)))
    else $error("Right port does not carry stored data.");
  a_capture_no_drive: assert property ( // R9
    (l2r_edge || r2l_edge) && $stable(ctrl_r) |=> $stable(left_port_lines_oe_n))
    else $error("Capture edge changed the port enable.");
  a_loaded_left: assert property ( // R14
    l2r_edge |=> l2r_loaded_r)
    else $error("Left loaded flag not set by its capture.");
  a_loaded_right: assert property ( // R14
    r2l_edge |=> r2l_loaded_r)
    else $error("Right loaded flag not set by its capture.");

  c_both_capture: cover property (l2r_edge && r2l_edge);
  c_stored_right: cover property (right_drv && ctrl_r[obt_pkg::CTRL_L2R_SEL] && l2r_edge);
  c_log_pop: cover property (log_pop ##2 s_axi_rvalid);
  c_live_left: cover property (left_drv && !ctrl_r[obt_pkg::CTRL_R2L_SEL]);
endmodule
`default_nettype wire

//--- obt_bus_partner.sv
`timescale 1ns/100ps
`default_nettype none
module obt_bus_partner (
  // Clock.
  input  wire logic       aclk,
  // Device side of both ports.
  input  wire logic [7:0] left_out,
  input  wire logic [7:0] left_oe_n,
  input  wire logic [7:0] right_out,
  input  wire logic [7:0] right_oe_n,
  // Resolved wire levels and capture clocks.
  output logic [7:0]      left_in,
  output logic [7:0]      right_in,
  output logic            l2r_clk,
  output logic            r2l_clk
);
  logic [7:0] left_val;
  logic [7:0] right_val;

  initial begin
    left_val  = 8'h00;
    right_val = 8'h00;
    l2r_clk   = 1'b0;
    r2l_clk   = 1'b0;
  end

  // drive released lines only
  // Each line shows the device where it drives, otherwise our own value.
  assign left_in  = (left_oe_n & left_val) | (~left_oe_n & left_out);
  assign right_in = (right_oe_n & right_val) | (~right_oe_n & right_out);

  // Data change just after an edge and stay put through the next capture.
  task automatic set_ports(input logic [7:0] l, input logic [7:0] r);
    @(posedge aclk);
    left_val  <= l;
    right_val <= r;
  endtask

  // Three cycles high and low, since the synchroniser needs two of each.
  task automatic pulse(input logic lc, input logic rc);
    repeat (3) @(posedge aclk);
    l2r_clk <= lc;
    r2l_clk <= rc;
    repeat (3) @(posedge aclk);
    l2r_clk <= 1'b0;
    r2l_clk <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        aclk, aresetn;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, q_s;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, log_ready;
  logic [1:0]  bresp, rresp, resp_s;
  logic [7:0]  l_in, l_out, l_oen, r_in, r_out, r_oen;
  logic        l2r_clk, r2l_clk;
  logic [15:0] lfsr;
  logic [7:0]  exp_l2r, exp_r2l;
  int          bad_count, num_checks;

  obt_transceiver u_obt_transceiver (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .left_to_right_capture_clock(l2r_clk), .right_to_left_capture_clock(r2l_clk),
    .left_port_lines_in(l_in), .left_port_lines_out(l_out),
    .left_port_lines_oe_n(l_oen), .right_port_lines_in(r_in),
    .right_port_lines_out(r_out), .right_port_lines_oe_n(r_oen),
    .capture_log_ready(log_ready)
  );

  obt_bus_partner u_obt_bus_partner (
    .aclk(aclk), .left_out(l_out), .left_oe_n(l_oen), .right_out(r_out),
    .right_oe_n(r_oen), .left_in(l_in), .right_in(r_in),
    .l2r_clk(l2r_clk), .r2l_clk(r2l_clk)
  );

  // Clock of 25 ns period.
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Sixteen-bit maximal-length shift register for repeatable stimulus.
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // The left port carries right data and the right port carries left data.
  function automatic logic [7:0] exp_drive(input logic dir, input logic sel,
                                           input logic [7:0] ll, input logic [7:0] lr);
    if (dir) return sel ? exp_l2r : ll;
    return sel ? exp_r2l : lr;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("Checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // One bus transfer; each channel is released at the edge that takes it.
  task automatic axi(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int   n;
    logic done;
    n    = 0;
    done = 1'b0;
    @(posedge aclk);
    if (wr) begin
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
    end else begin
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
    end
    while (!done) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if ((wr ? bvalid : rvalid) === 1'b1) begin
        done = 1'b1;
        q_s = rdata;
        resp_s = wr ? bresp : rresp;
        bready <= 1'b0;
        rready <= 1'b0;
      end
      if (n > 100) begin
        bad_count++;
        final_report();
      end
    end
  endtask

  task automatic wr_chk(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
    axi(1'b1, a, d);
    check({30'h0, resp_s}, {30'h0, er});
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
                        input logic [1:0] er);
    axi(1'b0, a, 32'h0);
    check(q_s & m, e);
    check({30'h0, resp_s}, {30'h0, er});
  endtask

  // Only the driven port shows low enables; the other stays released.
  task automatic port_chk(input logic dir, input logic [7:0] v);
    check({8'h0, l_oen, r_oen, dir ? r_out : l_out}, {8'h0, dir ? 16'hFF00 : 16'h00FF, v});
  endtask

  // Main sequence.
  initial begin
    logic [7:0] a, b, c, d;
    logic       dir, sel;
    aresetn = 1'b0;
    {awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    bad_count = 0;
    num_checks = 0;
    lfsr = 16'hBF92;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    check({16'h0, l_oen, r_oen}, 32'h0000_FFFF);
    rd_chk(obt_pkg::ADDR_CTRL, 32'hF, 32'h1, obt_pkg::RESP_OKAY);
    rd_chk(obt_pkg::ADDR_STATUS, 32'h30, 32'h0, obt_pkg::RESP_OKAY);
    // Every drive mode, with the unused select set at random.
    for (int m = 0; m < 4; m++) begin
      dir = m[0];
      sel = m[1];
      lfsr = lfsr_next(lfsr);
      {a, b} = lfsr;
      lfsr = lfsr_next(lfsr);
      {c, d} = lfsr;
      wr_chk(obt_pkg::ADDR_CTRL, 32'h1, obt_pkg::RESP_OKAY);
      u_obt_bus_partner.set_ports(a, b);
      u_obt_bus_partner.pulse(1'b1, 1'b1);
      exp_l2r = a;
      exp_r2l = b;
      u_obt_bus_partner.set_ports(c, d);
      wr_chk(obt_pkg::ADDR_CTRL, dir ? {28'h0, lfsr[0], sel, 2'b10}
                                     : {28'h0, sel, lfsr[0], 2'b00}, obt_pkg::RESP_OKAY);
      repeat (6) @(posedge aclk);
      port_chk(dir, exp_drive(dir, sel, c, d));
      rd_chk(obt_pkg::ADDR_STATUS, 32'h3C, dir ? 32'h38 : 32'h34, obt_pkg::RESP_OKAY);
      rd_chk(obt_pkg::ADDR_L2R, 32'hFF, {24'h0, a}, obt_pkg::RESP_OKAY);
      rd_chk(obt_pkg::ADDR_R2L, 32'hFF, {24'h0, b}, obt_pkg::RESP_OKAY);
    end
    // Capture while driving, then capture the driven port itself.
    lfsr = lfsr_next(lfsr);
    a = lfsr[7:0];
    wr_chk(obt_pkg::ADDR_CTRL, 32'h6, obt_pkg::RESP_OKAY);
    u_obt_bus_partner.set_ports(a, 8'h00);
    u_obt_bus_partner.pulse(1'b1, 1'b0);
    exp_l2r = a;
    port_chk(1'b1, a);
    u_obt_bus_partner.pulse(1'b0, 1'b1);
    port_chk(1'b1, a);
    rd_chk(obt_pkg::ADDR_R2L, 32'hFF, {24'h0, a}, obt_pkg::RESP_OKAY);
    // Unmapped and misaligned places are refused.
    rd_chk(5'h14, 32'hFFFF_FFFF, 32'h0, obt_pkg::RESP_SLVERR);
    wr_chk(5'h01, 32'h0, obt_pkg::RESP_SLVERR);
    wr_chk(obt_pkg::ADDR_CTRL, 32'h1, obt_pkg::RESP_OKAY);
    repeat (3) @(posedge aclk);
    check({16'h0, l_oen, r_oen}, 32'h0000_FFFF);
    // Empty the log, overfill it by one, then drain it in order.
    for (int i = 0; i < 24; i++) axi(1'b0, obt_pkg::ADDR_LOG, 32'h0);
    rd_chk(obt_pkg::ADDR_LOG, 32'hFFFF_FFFF, 32'h0, obt_pkg::RESP_OKAY);
    for (int i = 0; i < 17; i++) begin
      u_obt_bus_partner.set_ports(i[7:0], 8'h5A);
      u_obt_bus_partner.pulse(1'b1, 1'b0);
    end
    check({31'h0, log_ready}, 32'h0);
    rd_chk(obt_pkg::ADDR_STATUS, 32'h43, 32'h43, obt_pkg::RESP_OKAY);
    for (int i = 0; i < 16; i++)
      rd_chk(obt_pkg::ADDR_LOG, 32'hFFFF_FFFF, 32'h8001_5A00 | i, obt_pkg::RESP_OKAY);
    rd_chk(obt_pkg::ADDR_LOG, 32'hFFFF_FFFF, 32'h0, obt_pkg::RESP_OKAY);
    check({31'h0, log_ready}, 32'h1);
    wr_chk(obt_pkg::ADDR_STATUS, 32'h40, obt_pkg::RESP_OKAY);
    rd_chk(obt_pkg::ADDR_STATUS, 32'h43, 32'h0, obt_pkg::RESP_OKAY);
    final_report();
  end

  // Watchdog: the whole run needs well under a tenth of this span.
  initial begin
    repeat (40000) @(posedge aclk);
    bad_count++;
    final_report();
  end
endmodule
`default_nettype wire
